/* rtl/swtbm_pkg.sv */
// swtbm_pkg: constants and the state struct of the sleep wake timer and battery monitor.
// assumes a 10 MHz system clock and a byte-wide register port driven by the spi slave.
`default_nettype none
package swtbm_pkg;
  // register offsets
  localparam logic [7:0] ADDR_WAKE_PERIOD_EXPONENT = 8'h14;
  localparam logic [7:0] ADDR_WAKE_PERIOD_MANTISSA_HIGH = 8'h15;
  localparam logic [7:0] ADDR_WAKE_PERIOD_MANTISSA_LOW = 8'h16;
  localparam logic [7:0] ADDR_WAKE_COUNT_HIGH = 8'h17;
  localparam logic [7:0] ADDR_WAKE_COUNT_LOW = 8'h18;
  localparam logic [7:0] ADDR_BATTERY_THRESHOLD = 8'h1A;
  localparam logic [7:0] ADDR_BATTERY_LEVEL = 8'h1B;
  // reset values
  localparam logic [4:0] RST_WAKE_EXPONENT = 5'h03;
  localparam logic [15:0] RST_WAKE_MANTISSA = 16'h0000;
  localparam logic [4:0] RST_BATTERY_THRESHOLD = 5'h14;
  // gpio routing code that selects the wake period output
  localparam logic [4:0] GPIO_WAKE_PERIOD_SEL = 5'h01;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RC_OSC_HZ = 32_768;
  localparam int PRESCALE_BASE = 32; // low frequency ticks per mantissa unit at exponent 0
  localparam int MEAS_PERIOD_S = 1;
  localparam int MEAS_PERIOD_CYC = MEAS_PERIOD_S * CLK_HZ;
  localparam int MEAS_ON_NS = 250_000;
  localparam int MEAS_ON_CYC = (MEAS_ON_NS / CLK_PERIOD_NS) < 1 ? 1 : (MEAS_ON_NS / CLK_PERIOD_NS);
  localparam int LOW_RUN_NEEDED = 4;
  // power modes seen by this block
  typedef enum logic [1:0] {
    SWTBM_ST_AWAKE = 2'b00,
    SWTBM_ST_SLEEP = 2'b01,
    SWTBM_ST_READY = 2'b10
  } swtbm_mode_e;
  // complete state of the block
  typedef struct packed {
    logic [4:0] exponent;
    logic [15:0] mantissa;
    logic [4:0] threshold;
    logic [15:0] wake_count;
    logic [36:0] prescale;
    logic [23:0] rc_acc;
    logic [2:0] xtal_sync;
    logic xtal_level;
    logic [4:0] code_s1;
    logic [4:0] code_s2;
    logic [4:0] code_s3;
    logic [4:0] battery_level;
    logic [23:0] meas_cnt;
    logic [11:0] on_cnt;
    logic [2:0] low_run;
    swtbm_mode_e mode;
    logic armed;
    logic wake_flag;
    logic battery_flag;
    logic irq_n;
    logic xtal_on;
    logic mcu_clk_en;
    logic gpio_wake;
    logic adc_power;
    logic rc_osc_en;
    logic gpio0_xtal;
    logic [7:0] rdata;
  } swtbm_state_s;
endpackage : swtbm_pkg
`default_nettype wire

/* rtl/swtbm_core.sv */
// swtbm_core: wake timer and low battery detector of the sleep housekeeping block.
// assumes a register port strobed on clk_sys_i, the mode command and control bits from
// the chip's control registers, a 5-bit supply code from the analog converter and the
// optional 32 kHz crystal level, both from outside the clock domain.
//
// Overview of operation
// [RL1] wake timer ticks from the internal 32.768 kHz rc source by default
// [RL2] timer runs only if its enable is set when sleep is entered
// [RL3] period is 32 x mantissa x 2^exponent low frequency ticks
// [RL4] expiry with wake interrupt enabled asserts the interrupt; host reads status
// [RL5] live 16-bit count readable anytime, high byte at lower address
// [RL6] wake interrupt pulls interrupt low and starts the 30 MHz crystal
// [RL7] without wake interrupt, routed gpio pulses on expiry and chip stays asleep
// [RL8] external crystal select turns gpio0 into crystal pin and clocks the timer
// [RL9] battery detector works only while its enable is set
// [RL10] detector enabled in sleep keeps the rc oscillator running; code stops it while external crystal select is set
// [RL11] detector and converter powered about 250 us once every 1 s
// [RL12] supply code is 5 bits, 50 mV steps from 1.7 V
// [RL13] latest supply code readable at 1Bh, upper three bits zero
// [RL14] supply below threshold with interrupt enabled raises an interrupt
// [RL15] interrupt fires only after four consecutive low measurements
// [RL16] pending interrupt keeps mcu clock on; sleep waits until status is read
// [RL17] after expiry count restarts at zero while sleep and enable persist
`default_nettype none
module swtbm_core
  import swtbm_pkg::*;
#(
  parameter int MEAS_PERIOD = MEAS_PERIOD_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // mode command and control bits
  input wire logic sleep_cmd_i,
  input wire logic wake_timer_enable_i,
  input wire logic battery_detector_enable_i,
  input wire logic external_crystal_select_i,
  input wire logic wake_irq_enable_i,
  input wire logic battery_irq_enable_i,
  input wire logic [4:0] gpio_route_i,
  input wire logic status_read_i,
  // analog and pin side
  input wire logic [4:0] battery_code_i,
  input wire logic xtal32_i,
  // status and control outputs
  output logic interrupt_request_low_o,
  output logic wake_status_o,
  output logic battery_status_o,
  output logic in_sleep_o,
  output logic xtal_on_o,
  output logic mcu_clk_en_o,
  output logic gpio_wake_pulse_o,
  output logic battery_adc_power_o,
  output logic rc_osc_en_o,
  output logic gpio0_crystal_mode_o
);

  localparam logic [23:0] RC_STEP = 24'(RC_OSC_HZ);
  localparam logic [23:0] RC_WRAP = 24'(CLK_HZ);
  localparam logic [23:0] MEAS_LAST = 24'(MEAS_PERIOD - 1);
  localparam logic [11:0] ON_LAST = 12'(MEAS_ON_CYC - 1);
  localparam logic [2:0] RUN_FULL = 3'(LOW_RUN_NEEDED);
  localparam logic [36:0] PRESCALE_ONE = 37'(PRESCALE_BASE);

  swtbm_state_s st;
  swtbm_state_s next_st;

  // next state of the whole block
  always_comb begin
    logic rc_tick;
    logic xtal_tick;
    logic lf_tick;
    logic [23:0] acc_sum;
    logic [36:0] limit;
    logic expire;
    logic sleep_eff;
    logic meas_done;
    logic below;
    logic wake_set;
    logic batt_set;
    rc_tick = 1'b0;
    xtal_tick = 1'b0;
    lf_tick = 1'b0;
    acc_sum = 24'h000000;
    limit = 37'h0000000000;
    expire = 1'b0;
    sleep_eff = 1'b0;
    meas_done = 1'b0;
    below = 1'b0;
    wake_set = 1'b0;
    batt_set = 1'b0;
    next_st = st;

    // register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_WAKE_PERIOD_EXPONENT: next_st.exponent = reg_wdata_i[4:0];
        ADDR_WAKE_PERIOD_MANTISSA_HIGH: next_st.mantissa[15:8] = reg_wdata_i;
        ADDR_WAKE_PERIOD_MANTISSA_LOW: next_st.mantissa[7:0] = reg_wdata_i;
        ADDR_BATTERY_THRESHOLD: next_st.threshold = reg_wdata_i[4:0];
        default: ;
      endcase
    end

    // rc oscillator rate from a fractional accumulator
    acc_sum = st.rc_acc + RC_STEP;
    if (acc_sum >= RC_WRAP) begin
      next_st.rc_acc = acc_sum - RC_WRAP;
      rc_tick = 1'b1; // RL1
    end else begin
      next_st.rc_acc = acc_sum;
    end

    // external crystal level, accepted once stages two and three agree
    next_st.xtal_sync = {st.xtal_sync[1:0], xtal32_i};
    if (st.xtal_sync[1] == st.xtal_sync[2]) begin
      next_st.xtal_level = st.xtal_sync[2];
      xtal_tick = st.xtal_sync[2] & ~st.xtal_level;
    end
    next_st.gpio0_xtal = external_crystal_select_i; // RL8
    lf_tick = external_crystal_select_i ? xtal_tick : rc_tick; // RL8

    // effective mode: a pending interrupt holds the chip out of sleep
    sleep_eff = sleep_cmd_i & ~(st.wake_flag | st.battery_flag); // RL16

    // wake timer arming and counting
    limit = PRESCALE_ONE << st.exponent; // RL3
    if (!sleep_cmd_i || !wake_timer_enable_i) begin
      next_st.armed = 1'b0;
    end else if (sleep_eff && st.mode != SWTBM_ST_SLEEP && !st.armed) begin
      next_st.armed = 1'b1; // RL2
      next_st.prescale = 37'h0000000000;
      next_st.wake_count = 16'h0000;
    end else if (st.armed && lf_tick) begin
      if (st.prescale + 37'h0000000001 >= limit) begin
        next_st.prescale = 37'h0000000000;
        if (st.wake_count + 16'h0001 >= st.mantissa || st.mantissa == 16'h0000) begin
          next_st.wake_count = 16'h0000; // RL17
          expire = 1'b1; // RL3
        end else begin
          next_st.wake_count = st.wake_count + 16'h0001;
        end
      end else begin
        next_st.prescale = st.prescale + 37'h0000000001;
      end
    end

    // expiry routing
    wake_set = expire & wake_irq_enable_i; // RL4
    next_st.gpio_wake = expire & ~wake_irq_enable_i & (gpio_route_i == GPIO_WAKE_PERIOD_SEL); // RL7

    // battery measurement schedule
    if (!battery_detector_enable_i) begin
      next_st.meas_cnt = 24'h000000; // RL9
      next_st.on_cnt = 12'h000;
      next_st.adc_power = 1'b0;
      next_st.low_run = 3'h0;
    end else if (st.adc_power) begin
      if (st.on_cnt == ON_LAST) begin
        next_st.adc_power = 1'b0;
        meas_done = 1'b1; // RL11
      end else begin
        next_st.on_cnt = st.on_cnt + 12'h001;
      end
    end else if (st.meas_cnt == MEAS_LAST) begin
      next_st.meas_cnt = 24'h000000;
      next_st.on_cnt = 12'h000;
      next_st.adc_power = 1'b1; // RL11
    end else begin
      next_st.meas_cnt = st.meas_cnt + 24'h000001;
    end

    // supply code synchroniser
    next_st.code_s1 = battery_code_i;
    next_st.code_s2 = st.code_s1;
    next_st.code_s3 = st.code_s2;
    if (meas_done && st.code_s2 == st.code_s3) begin
      next_st.battery_level = st.code_s3; // RL12
      below = st.code_s3 < st.threshold; // RL14
      if (!below) begin
        next_st.low_run = 3'h0;
      end else if (st.low_run != RUN_FULL) begin
        next_st.low_run = st.low_run + 3'h1; // RL15
        batt_set = (st.low_run + 3'h1 == RUN_FULL) & battery_irq_enable_i; // RL15
      end
    end

    // sticky interrupt flags, a set in the clearing cycle wins
    if (status_read_i) begin
      next_st.wake_flag = 1'b0; // RL4
      next_st.battery_flag = 1'b0;
    end
    if (wake_set) begin
      next_st.wake_flag = 1'b1; // RL6
    end
    if (batt_set) begin
      next_st.battery_flag = 1'b1; // RL14
    end
    next_st.irq_n = ~(next_st.wake_flag | next_st.battery_flag); // RL6

    // power mode outputs
    if (!sleep_cmd_i) begin
      next_st.mode = SWTBM_ST_AWAKE;
    end else if (next_st.wake_flag | next_st.battery_flag) begin
      next_st.mode = SWTBM_ST_READY; // RL16
    end else begin
      next_st.mode = SWTBM_ST_SLEEP; // RL7
    end
    next_st.xtal_on = next_st.mode != SWTBM_ST_SLEEP; // RL6
    next_st.mcu_clk_en = next_st.mode != SWTBM_ST_SLEEP; // RL16
    next_st.rc_osc_en = ~external_crystal_select_i
      & (battery_detector_enable_i | (wake_timer_enable_i & sleep_cmd_i)); // RL10

    // register reads
    next_st.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_WAKE_PERIOD_EXPONENT: next_st.rdata = {3'h0, st.exponent};
        ADDR_WAKE_PERIOD_MANTISSA_HIGH: next_st.rdata = st.mantissa[15:8];
        ADDR_WAKE_PERIOD_MANTISSA_LOW: next_st.rdata = st.mantissa[7:0];
        ADDR_WAKE_COUNT_HIGH: next_st.rdata = st.wake_count[15:8]; // RL5
        ADDR_WAKE_COUNT_LOW: next_st.rdata = st.wake_count[7:0]; // RL5
        ADDR_BATTERY_THRESHOLD: next_st.rdata = {3'h0, st.threshold};
        ADDR_BATTERY_LEVEL: next_st.rdata = {3'h0, st.battery_level}; // RL13
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '0;
      st.exponent <= RST_WAKE_EXPONENT;
      st.mantissa <= RST_WAKE_MANTISSA;
      st.threshold <= RST_BATTERY_THRESHOLD;
      st.mode <= SWTBM_ST_AWAKE;
      st.irq_n <= 1'b1;
      st.xtal_on <= 1'b1;
      st.mcu_clk_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = st.rdata;
  assign interrupt_request_low_o = st.irq_n;
  assign wake_status_o = st.wake_flag;
  assign battery_status_o = st.battery_flag;
  assign in_sleep_o = st.mode == SWTBM_ST_SLEEP;
  assign xtal_on_o = st.xtal_on;
  assign mcu_clk_en_o = st.mcu_clk_en;
  assign gpio_wake_pulse_o = st.gpio_wake;
  assign battery_adc_power_o = st.adc_power;
  assign rc_osc_en_o = st.rc_osc_en;
  assign gpio0_crystal_mode_o = st.gpio0_xtal;

endmodule : swtbm_core
`default_nettype wire

/* verification/swtbm_assertions.sv */
// swtbm_chk: port checks of the sleep wake timer and battery monitor.
// assumes it is bound to swtbm_core and sees only its ports.
`default_nettype none
module swtbm_chk
  import swtbm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // controls
  input wire logic wake_irq_enable_i,
  input wire logic battery_detector_enable_i,
  input wire logic [4:0] gpio_route_i,
  // status outputs
  input wire logic interrupt_request_low_o,
  input wire logic wake_status_o,
  input wire logic battery_status_o,
  input wire logic in_sleep_o,
  input wire logic mcu_clk_en_o,
  input wire logic gpio_wake_pulse_o,
  input wire logic battery_adc_power_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] on_len;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // length of the current converter power window
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !battery_adc_power_o)
      on_len <= 12'h000;
    else
      on_len <= on_len + 12'h001;
  end
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_level_top: assert property (reg_rd_i && reg_addr_i == ADDR_BATTERY_LEVEL
    |=> reg_rdata_o[7:5] == 3'h0) else $error("level upper bits set");
  a_irq_cause: assert property ($fell(interrupt_request_low_o)
    |-> wake_status_o || battery_status_o) else $error("interrupt without cause");
  a_wake_ready: assert property ($rose(wake_status_o) && wake_irq_enable_i
    |-> ##[0:1] (!in_sleep_o && !interrupt_request_low_o)) else $error("no wake");
  a_gpio_pulse: assert property (gpio_wake_pulse_o
    |-> gpio_route_i == GPIO_WAKE_PERIOD_SEL ##1 !gpio_wake_pulse_o) else $error("bad pulse");
  a_adc_off: assert property (!battery_detector_enable_i |=> !battery_adc_power_o)
    else $error("converter powered while off");
  a_adc_window: assert property ($fell(battery_adc_power_o) && battery_detector_enable_i
    |-> on_len == 12'(MEAS_ON_CYC)) else $error("window length wrong");
  a_clk_pending: assert property (!interrupt_request_low_o |-> mcu_clk_en_o)
    else $error("clock off while pending");
  a_sleep_hold: assert property (wake_status_o && $past(wake_status_o) |-> !in_sleep_o)
    else $error("asleep while pending");
endmodule // swtbm_chk
bind swtbm_core swtbm_chk u_chk (
  .clk_sys_i, .srst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .wake_irq_enable_i,
  .battery_detector_enable_i, .gpio_route_i, .interrupt_request_low_o, .wake_status_o,
  .battery_status_o, .in_sleep_o, .mcu_clk_en_o, .gpio_wake_pulse_o, .battery_adc_power_o
);
`default_nettype wire

/* verification/swtbm_host.sv */
// swtbm_host: microcontroller model that services the interrupt pin.
// assumes the bench sets service_i and slow_i at falling edges.
`default_nettype none
module swtbm_host (
  // clock
  input wire logic clk_sys_i,
  // interrupt pin and control
  input wire logic interrupt_request_low_i,
  input wire logic service_i,
  input wire logic slow_i,
  // status read strobe
  output logic status_read_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial status_read_o = 1'b0;
  // after a prompt or slow delay, read the status once per interrupt
  always begin
    @(negedge clk_sys_i);
    if (service_i && interrupt_request_low_i === 1'b0) begin
      repeat (slow_i ? 40 : 2) @(negedge clk_sys_i);
      status_read_o = 1'b1;
      @(negedge clk_sys_i);
      status_read_o = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
  end
endmodule // swtbm_host
`default_nettype wire

/* verification/tb_top.sv */
// tb_top: self-checking bench of the sleep wake timer and battery monitor.
// assumes a 5000-cycle measurement period and the host model on the interrupt pin.
`default_nettype none
module tb_top
  import swtbm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, srst_i, reg_wr_i, reg_rd_i, sleep_cmd_i, wake_timer_enable_i, xtal32_i;
  logic battery_detector_enable_i, external_crystal_select_i, wake_irq_enable_i;
  logic battery_irq_enable_i, status_read_i, xtal_run, service, slow;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [4:0] gpio_route_i, battery_code_i;
  logic interrupt_request_low_o, wake_status_o, battery_status_o, in_sleep_o, xtal_on_o;
  logic mcu_clk_en_o, gpio_wake_pulse_o, battery_adc_power_o, rc_osc_en_o;
  logic gpio0_crystal_mode_o;
  int n_errors = 0;
  int check_count = 0;
  int n;
  longint t0;
  swtbm_core #(.MEAS_PERIOD(5000)) dut (
    .clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .sleep_cmd_i, .wake_timer_enable_i, .battery_detector_enable_i,
    .external_crystal_select_i, .wake_irq_enable_i, .battery_irq_enable_i, .gpio_route_i,
    .status_read_i, .battery_code_i, .xtal32_i, .interrupt_request_low_o, .wake_status_o,
    .battery_status_o, .in_sleep_o, .xtal_on_o, .mcu_clk_en_o, .gpio_wake_pulse_o,
    .battery_adc_power_o, .rc_osc_en_o, .gpio0_crystal_mode_o
  );
  swtbm_host host (
    .clk_sys_i, .interrupt_request_low_i(interrupt_request_low_o), .service_i(service),
    .slow_i(slow), .status_read_o(status_read_i)
  );
  // 10 MHz clock; crystal stand-in with a 2 us period while running
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always #1000 if (xtal_run) xtal32_i = ~xtal32_i;
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys_i);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return interrupt_request_low_o;
      1: return gpio_wake_pulse_o;
      default: return battery_adc_power_o;
    endcase
  endfunction
  // wait until an output takes a value, giving up after lim cycles
  task automatic wait_for(input int w, input logic v, input int lim);
    n = 0;
    while (sig(w) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = wd;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d === e, "read data");
  endtask
  task automatic t_regs();
    rdchk(ADDR_WAKE_PERIOD_EXPONENT, {3'h0, RST_WAKE_EXPONENT});
    rdchk(ADDR_WAKE_PERIOD_MANTISSA_HIGH, RST_WAKE_MANTISSA[15:8]);
    rdchk(ADDR_BATTERY_THRESHOLD, {3'h0, RST_BATTERY_THRESHOLD});
    wr(ADDR_WAKE_PERIOD_EXPONENT, 8'hFF);
    rdchk(ADDR_WAKE_PERIOD_EXPONENT, 8'h1F);
    wr(ADDR_WAKE_COUNT_LOW, 8'h55);
    rdchk(ADDR_WAKE_COUNT_LOW, 8'h00);
    rdchk(8'h7F, 8'h00);
    wr(ADDR_WAKE_PERIOD_EXPONENT, 8'h00);
    wr(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h01);
    rdchk(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h01);
    $display("regs test done");
  endtask
  task automatic t_wake();
    wake_irq_enable_i = 1'b1;
    wake_timer_enable_i = 1'b1;
    sleep_cmd_i = 1'b1;
    t0 = $time;
    cyc(3);
    chk(in_sleep_o === 1'b1, "not asleep");
    for (int k = 0; k < 2; k++) begin
      wait_for(0, 1'b0, 12000);
      chk($time - t0 > 930_000 && $time - t0 < 1_020_000, "wake period");
      t0 = $time;
      cyc(2);
      chk(!in_sleep_o && xtal_on_o && wake_status_o, "wake state");
      cyc(100);
      chk(!interrupt_request_low_o && mcu_clk_en_o && !in_sleep_o, "pending");
      service = 1'b1;
      cyc(20);
      chk(interrupt_request_low_o && in_sleep_o, "no resleep");
      service = 1'b0;
      if (k == 0) begin
        cyc(3000);
        rdchk(ADDR_WAKE_COUNT_HIGH, 8'h00);
        rd(ADDR_WAKE_COUNT_LOW);
        chk(d === 8'h00, "count low");
      end
    end
    sleep_cmd_i = 1'b0;
    wake_irq_enable_i = 1'b0;
    $display("wake test done");
  endtask
  task automatic t_xtal();
    gpio_route_i = GPIO_WAKE_PERIOD_SEL;
    external_crystal_select_i = 1'b1;
    xtal_run = 1'b1;
    cyc(5);
    chk(gpio0_crystal_mode_o === 1'b1, "crystal pin");
    sleep_cmd_i = 1'b1;
    wait_for(1, 1'b1, 2000);
    chk(n > 610 && n < 700, "crystal period");
    cyc(3);
    chk(interrupt_request_low_o && in_sleep_o, "left sleep");
    sleep_cmd_i = 1'b0;
    wake_timer_enable_i = 1'b0;
    external_crystal_select_i = 1'b0;
    xtal_run = 1'b0;
    $display("crystal test done");
  endtask
  task automatic meas();
    wait_for(2, 1'b1, 6000);
    wait_for(2, 1'b0, 3000);
    chk(n < 3000, "measurement");
    cyc(2);
  endtask
  task automatic t_batt();
    battery_code_i = 5'h19;
    battery_irq_enable_i = 1'b1;
    battery_detector_enable_i = 1'b1;
    sleep_cmd_i = 1'b1;
    meas();
    chk(rc_osc_en_o === 1'b1, "rc off");
    rdchk(ADDR_BATTERY_LEVEL, 8'h19);
    battery_code_i = 5'h0A;
    for (int k = 0; k < 4; k++) begin
      chk(battery_status_o === 1'b0, "early flag");
      meas();
    end
    cyc(3);
    chk(battery_status_o && !interrupt_request_low_o, "no low flag");
    slow = 1'b1;
    service = 1'b1;
    cyc(60);
    chk(interrupt_request_low_o === 1'b1, "not cleared");
    battery_detector_enable_i = 1'b0;
    wait_for(2, 1'b1, 6000);
    chk(n == 6000, "powered while off");
    $display("battery test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence: inputs quiet, reset for 10 cycles, then each test
  initial begin
    {srst_i, reg_wr_i, reg_rd_i, sleep_cmd_i, wake_timer_enable_i, xtal32_i} = 6'h20;
    {battery_detector_enable_i, external_crystal_select_i, wake_irq_enable_i} = 3'h0;
    {battery_irq_enable_i, xtal_run, service, slow} = 4'h0;
    {reg_addr_i, reg_wdata_i, gpio_route_i, battery_code_i} = 26'h0;
    cyc(10);
    srst_i = 1'b0;
    t_regs();
    t_wake();
    t_xtal();
    t_batt();
    end_of_test();
  end
  // watchdog
  initial begin
    #9_000_000;
    n_errors++;
    $display("unexpected at %0t: watchdog", $time);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
